// ### core/rpp_pkg.sv
// Package: constants and types for the render observer report packer
`default_nettype none
package rpp_pkg;
	localparam int NUM_A = 36;
	localparam int NUM_A_HI = 32;
	localparam int NUM_B = 8;
	localparam int NUM_C = 8;
	localparam int CNT_W = 40;
	localparam int IDX_W = 7;
	// Register indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_SOURCE = 4'h2;
	localparam logic [3:0] REG_TRIG = 4'h3;
	localparam logic [3:0] REG_TICKS = 4'h4;
	localparam logic [3:0] REG_RPTCNT = 4'h5;
	// Control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam int CTRL_SEL_LSB = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Trigger config fields: start event 1/2, threshold enable 1/2
	localparam int TRIG_SE1 = 0;
	localparam int TRIG_SE2 = 1;
	localparam int TRIG_TE1 = 2;
	localparam int TRIG_TE2 = 3;
	// Header field positions
	localparam int HDR_SRC_LSB = 26;
	localparam int HDR_CAUSE_LSB = 19;
	localparam int HDR_START_BIT = 18;
	localparam int HDR_THRESH_BIT = 17;
	// Cause bits
	localparam int CAUSE_TIMER = 0;
	localparam int CAUSE_TRIG1 = 1;
	localparam int CAUSE_TRIG2 = 2;
	localparam int CAUSE_CTXSW = 3;
	localparam int CAUSE_RUNFALL = 4;
	localparam int CAUSE_RATIO = 5;
	localparam int CAUSE_MMIO = 6;
	// Layout selects
	localparam logic [2:0] SEL_000 = 3'h0;
	localparam logic [2:0] SEL_010 = 3'h2;
	localparam logic [2:0] SEL_101 = 3'h5;
	localparam logic [2:0] SEL_111 = 3'h7;
	// Report lengths in dwords
	localparam logic [IDX_W-1:0] LEN_000 = 7'h10;
	localparam logic [IDX_W-1:0] LEN_010 = 7'h20;
	localparam logic [IDX_W-1:0] LEN_101 = 7'h40;
	localparam logic [IDX_W-1:0] LEN_111 = 7'h10;
	localparam logic [IDX_W-1:0] LEN_HDR = 7'h4;
	typedef enum logic [1:0] {RPP_IDLE, RPP_EMIT} rpp_state_t;
endpackage : rpp_pkg
`default_nettype wire

// ### core/rpp_report_packer.sv
// Render observer: counters, context save/restore, report packing
//
// Operation
// - Observer resets and clocks together with the render engine.
// - Counters are saved and restored with the render context; the image holds low dwords only, so high bytes restore as zero.
// - Reports only come from explicit snapshot request commands.
// - Observer enable is independent of the global observer enable.
// - Select 101: header, A0-35 low, A0-31 high bytes, B0-7, C0-7.
// - Global observer uses the same 101 layout.
// - Select 111: header, C0-3, then B0-7.
// - Select 010: header, A7,9,11-15,17 low dwords, then B and C.
// - Select 000: header, then A8,11,13,14,16 low dwords.
// - Tick count runs freely and holds value while clocks gated.
// - Context tag word carries active context identifier.
// - Timestamp word carries command streamer timestamp format.
// - Header bits 31:26 hold requester source code.
// - Cause bits 0-2: timer, trigger one, trigger two.
// - Cause bit 3 context switch, bit 4 run flag falling.
// - Cause bit 5 clock ratio change, bit 6 register-write trigger.
// - Header bit 18 shows start event, trigger one priority.
// - Header bit 17 shows threshold enable, trigger one priority.
// - Counters increment only while context pause/resume bit is set.
// - 40-bit counters captured atomically, split low dword and high byte.
`default_nettype none
module rpp_report_packer (
	input  wire logic                            i_core_clk,
	input  wire logic                            i_reset,
	input  wire logic                            i_clk_gated,
	input  wire logic [3:0]                      i_reg_addr,
	input  wire logic [31:0]                     i_reg_wdata,
	input  wire logic                            i_reg_wr,
	input  wire logic                            i_reg_rd,
	output logic      [31:0]                     o_reg_rdata,
	input  wire logic [rpp_pkg::NUM_A-1:0]       i_a_event,
	input  wire logic [rpp_pkg::NUM_B-1:0]       i_b_event,
	input  wire logic [rpp_pkg::NUM_C-1:0]       i_c_event,
	input  wire logic                            i_ctx_save,
	input  wire logic                            i_ctx_restore,
	input  wire logic [5:0]                      i_ctx_save_idx,
	input  wire logic [31:0]                     i_ctx_restore_data,
	output logic      [31:0]                     o_ctx_save_data,
	input  wire logic                            i_ctx_switch,
	input  wire logic                            i_ratio_change,
	input  wire logic [31:0]                     i_context_tag,
	input  wire logic [31:0]                     i_timestamp,
	input  wire logic                            i_snap_req,
	output logic                                 o_snap_ready,
	output logic                                 o_rpt_valid,
	input  wire logic                            i_rpt_ready,
	output logic      [31:0]                     o_rpt_data,
	output logic      [rpp_pkg::IDX_W-1:0]       o_rpt_index,
	output logic                                 o_rpt_last
);
	localparam int NCNT = rpp_pkg::NUM_A + rpp_pkg::NUM_B + rpp_pkg::NUM_C;

	logic [31:0]                ctrl;
	logic [31:0]                source;
	logic [31:0]                trig;
	logic [31:0]                ticks;
	logic [31:0]                rpt_count;
	logic [rpp_pkg::CNT_W-1:0]  cnt [NCNT];
	logic [rpp_pkg::CNT_W-1:0]  snap [NCNT];
	logic [31:0]                hdr;
	logic [31:0]                ts_snap;
	logic [31:0]                tag_snap;
	logic [31:0]                tick_snap;
	logic [6:0]                 pend_cause;
	logic                       run_d;
	rpp_pkg::rpp_state_t        state;
	logic [rpp_pkg::IDX_W-1:0]  idx;
	logic [rpp_pkg::IDX_W-1:0]  rpt_len;
	logic [2:0]                 sel_lat;
	logic [31:0]                next_data;
	logic [6:0]                 cause_now;
	logic                       cnt_en;
	logic                       snap_take;
	logic                       beat;
	logic [NCNT-1:0]            ev;

	assign ev = {i_c_event, i_b_event, i_a_event};
	assign cnt_en = ctrl[rpp_pkg::CTRL_EN_BIT] && ctrl[rpp_pkg::CTRL_RUN_BIT];
	assign o_snap_ready = (state == rpp_pkg::RPP_IDLE) && ctrl[rpp_pkg::CTRL_EN_BIT];
	assign snap_take = i_snap_req && o_snap_ready;
	assign beat = o_rpt_valid && i_rpt_ready;

	// Register writes; reset shared with the render engine
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ctrl <= rpp_pkg::CTRL_RESET;
			source <= 32'h0000_0000;
			trig <= 32'h0000_0000;
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				rpp_pkg::REG_CTRL: ctrl <= i_reg_wdata;
				rpp_pkg::REG_SOURCE: source <= i_reg_wdata;
				rpp_pkg::REG_TRIG: trig <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_reg_rd) begin
			unique case (i_reg_addr)
				rpp_pkg::REG_CTRL: o_reg_rdata <= ctrl;
				rpp_pkg::REG_STATUS: o_reg_rdata <= {30'h0, o_rpt_valid, cnt_en};
				rpp_pkg::REG_SOURCE: o_reg_rdata <= source;
				rpp_pkg::REG_TRIG: o_reg_rdata <= trig;
				rpp_pkg::REG_TICKS: o_reg_rdata <= ticks;
				rpp_pkg::REG_RPTCNT: o_reg_rdata <= rpt_count;
				default: o_reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_reg_rdata <= 32'h0000_0000;
		end
	end

	// Free-running tick count, frozen but kept while clocks gated
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ticks <= 32'h0000_0000;
		end else if (!i_clk_gated) begin
			ticks <= ticks + 32'h0000_0001;
		end
	end

	// Counters: increment, or restore from context image
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			for (int k = 0; k < NCNT; k++) begin
				cnt[k] <= '0;
			end
		end else if (i_ctx_restore) begin
			for (int k = 0; k < NCNT; k++) begin
				if (6'(k) == i_ctx_save_idx) begin
					cnt[k] <= {8'h00, i_restore_lo(k)};
				end
			end
		end else if (cnt_en && !i_clk_gated) begin
			for (int k = 0; k < NCNT; k++) begin
				if (ev[k]) begin
					cnt[k] <= cnt[k] + 40'h00_0000_0001;
				end
			end
		end
	end

	function automatic logic [31:0] i_restore_lo(input int k);
		i_restore_lo = (k >= 0) ? i_ctx_restore_data : 32'h0000_0000;
	endfunction : i_restore_lo

	// Context save image; low dword only, so high bytes are lost for every counter across save/restore
	always_comb begin
		o_ctx_save_data = 32'h0000_0000;
		for (int k = 0; k < NCNT; k++) begin
			if (6'(k) == i_ctx_save_idx) begin
				o_ctx_save_data = cnt[k][31:0];
			end
		end
	end

	// Run flag falling edge for cause bit 4
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			run_d <= 1'b0;
		end else begin
			run_d <= ctrl[rpp_pkg::CTRL_RUN_BIT];
		end
	end

	always_comb begin
		cause_now = pend_cause;
		cause_now[rpp_pkg::CAUSE_CTXSW] = pend_cause[rpp_pkg::CAUSE_CTXSW] | i_ctx_switch;
		cause_now[rpp_pkg::CAUSE_RUNFALL] = pend_cause[rpp_pkg::CAUSE_RUNFALL]
			| (run_d & ~ctrl[rpp_pkg::CTRL_RUN_BIT]);
		cause_now[rpp_pkg::CAUSE_RATIO] = pend_cause[rpp_pkg::CAUSE_RATIO] | i_ratio_change;
		cause_now[rpp_pkg::CAUSE_MMIO] = pend_cause[rpp_pkg::CAUSE_MMIO]
			| (i_reg_wr && i_reg_addr == rpp_pkg::REG_CTRL && i_reg_wdata[2]);
		cause_now[rpp_pkg::CAUSE_TIMER] = 1'b0;
		cause_now[rpp_pkg::CAUSE_TRIG1] = 1'b0;
		cause_now[rpp_pkg::CAUSE_TRIG2] = 1'b0;
	end

	// Pending causes accumulate until the next report; clear wins over new events, which go into that header
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			pend_cause <= 7'h00;
		end else if (snap_take) begin
			pend_cause <= 7'h00;
		end else begin
			pend_cause <= cause_now;
		end
	end

	function automatic logic [31:0] make_hdr(input logic [6:0] c, input logic [31:0] src,
		input logic [31:0] tg);
		logic [31:0] h;
		h = 32'h0000_0000;
		h[31:26] = src[5:0];
		h[25:19] = c;
		if (c[rpp_pkg::CAUSE_TRIG1] || !c[rpp_pkg::CAUSE_TRIG2]) begin
			h[rpp_pkg::HDR_START_BIT] = tg[rpp_pkg::TRIG_SE1];
			h[rpp_pkg::HDR_THRESH_BIT] = tg[rpp_pkg::TRIG_TE1];
		end else begin
			h[rpp_pkg::HDR_START_BIT] = tg[rpp_pkg::TRIG_SE2];
			h[rpp_pkg::HDR_THRESH_BIT] = tg[rpp_pkg::TRIG_TE2];
		end
		make_hdr = h;
	endfunction : make_hdr

	// Snapshot capture: all counters at once
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			for (int k = 0; k < NCNT; k++) begin
				snap[k] <= '0;
			end
			hdr <= 32'h0000_0000;
			ts_snap <= 32'h0000_0000;
			tag_snap <= 32'h0000_0000;
			tick_snap <= 32'h0000_0000;
			sel_lat <= rpp_pkg::SEL_000;
		end else if (snap_take) begin
			for (int k = 0; k < NCNT; k++) begin
				snap[k] <= cnt[k];
			end
			hdr <= make_hdr(cause_now, source, trig);
			ts_snap <= i_timestamp;
			tag_snap <= i_context_tag;
			tick_snap <= ticks;
			sel_lat <= ctrl[rpp_pkg::CTRL_SEL_LSB +: 3];
		end
	end

	always_comb begin
		unique case (sel_lat)
			rpp_pkg::SEL_000: rpt_len = rpp_pkg::LEN_000;
			rpp_pkg::SEL_010: rpt_len = rpp_pkg::LEN_010;
			rpp_pkg::SEL_111: rpt_len = rpp_pkg::LEN_111;
			default: rpt_len = rpp_pkg::LEN_101;
		endcase
	end

	function automatic logic [31:0] lo(input int k);
		lo = snap[k][31:0];
	endfunction : lo

	// Slot mapping per layout; unlisted slots are zero
	always_comb begin
		logic [6:0] s;
		logic [6:0] c;
		s = idx;
		next_data = 32'h0000_0000;
		c = s - rpp_pkg::LEN_HDR;
		if (s == 7'h0) begin
			next_data = hdr;
		end else if (s == 7'h1) begin
			next_data = ts_snap;
		end else if (s == 7'h2) begin
			next_data = tag_snap;
		end else if (s == 7'h3) begin
			next_data = tick_snap;
		end else begin
			unique case (sel_lat)
				rpp_pkg::SEL_000: begin
					unique case (s)
						7'h04: next_data = lo(8);
						7'h08: next_data = lo(11);
						7'h0a: next_data = lo(13);
						7'h0b: next_data = lo(14);
						7'h0c: next_data = lo(16);
						default: next_data = 32'h0000_0000;
					endcase
				end
				rpp_pkg::SEL_010: begin
					unique case (s)
						7'h04: next_data = lo(7);
						7'h06: next_data = lo(9);
						7'h08: next_data = lo(11);
						7'h09: next_data = lo(12);
						7'h0a: next_data = lo(13);
						7'h0b: next_data = lo(14);
						7'h0c: next_data = lo(15);
						7'h0e: next_data = lo(17);
						default: next_data = (s >= 7'h10) ? lo(int'(s) - 16 + 36)
							: 32'h0000_0000;
					endcase
				end
				rpp_pkg::SEL_111: begin
					if (s < 7'h8) begin
						next_data = lo(int'(s) - 4 + 44);
					end else begin
						next_data = lo(int'(s) - 8 + 36);
					end
				end
				default: begin
					if (c < 7'h24) begin
						next_data = lo(int'(c));
					end else if (c < 7'h2c) begin
						for (int j = 0; j < 4; j++) begin
							next_data[8*j +: 8] = snap[(int'(c) - 36) * 4 + j][39:32];
						end
					end else begin
						next_data = lo(int'(c) - 44 + 36);
					end
				end
			endcase
		end
	end

	// Emit sequencer: one report per accepted request
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state <= rpp_pkg::RPP_IDLE;
			idx <= '0;
			o_rpt_valid <= 1'b0;
			o_rpt_data <= 32'h0000_0000;
			o_rpt_index <= '0;
			o_rpt_last <= 1'b0;
			rpt_count <= 32'h0000_0000;
		end else begin
			unique case (state)
				rpp_pkg::RPP_IDLE: begin
					if (snap_take) begin
						state <= rpp_pkg::RPP_EMIT;
						idx <= '0;
						rpt_count <= rpt_count + 32'h0000_0001;
					end
				end
				rpp_pkg::RPP_EMIT: begin
					if (!o_rpt_valid || beat) begin
						if (beat && o_rpt_last) begin
							o_rpt_valid <= 1'b0;
							o_rpt_last <= 1'b0;
							state <= rpp_pkg::RPP_IDLE;
						end else begin
							o_rpt_valid <= 1'b1;
							o_rpt_data <= next_data;
							o_rpt_index <= idx;
							o_rpt_last <= (idx == rpt_len - 7'h1);
							idx <= idx + 7'h1;
						end
					end
				end
			endcase
		end
	end

	a_no_req_busy: assert property (@(posedge i_core_clk) disable iff (i_reset)
		state == rpp_pkg::RPP_EMIT |-> !o_snap_ready)
		else $error("snapshot accepted while a report is in flight");
	a_hdr_first: assert property (@(posedge i_core_clk) disable iff (i_reset)
		snap_take |=> ##1 (o_rpt_valid && o_rpt_index == 7'h0))
		else $error("header word is not the first slot");
	a_hdr_reserved: assert property (@(posedge i_core_clk) disable iff (i_reset)
		o_rpt_valid && o_rpt_index == 7'h0 |-> o_rpt_data[16:0] == 17'h0)
		else $error("reserved header bits not zero");
	a_no_timer_cause: assert property (@(posedge i_core_clk) disable iff (i_reset)
		o_rpt_valid && o_rpt_index == 7'h0 |-> o_rpt_data[21:19] == 3'h0)
		else $error("internal or timer cause in report");
	a_src_code: assert property (@(posedge i_core_clk) disable iff (i_reset)
		snap_take |=> hdr[31:26] == $past(source[5:0]))
		else $error("source code mismatch");
	a_tick_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
		i_clk_gated |=> ticks == $past(ticks))
		else $error("tick count moved while clocks gated");
	a_cnt_pause: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!cnt_en && !i_ctx_restore |=> cnt[0] == $past(cnt[0]))
		else $error("counter moved while paused");
	a_ctxsw_cause: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_ctx_switch || pend_cause[rpp_pkg::CAUSE_CTXSW]) && snap_take
			|=> hdr[rpp_pkg::HDR_CAUSE_LSB + 3])
		else $error("context switch cause lost");
	a_tag_capture: assert property (@(posedge i_core_clk) disable iff (i_reset)
		snap_take |=> tag_snap == $past(i_context_tag))
		else $error("context tag not captured");
	c_report_101: cover property (@(posedge i_core_clk) snap_take && ctrl[6:4] == 3'h5);
	c_report_111: cover property (@(posedge i_core_clk) snap_take && ctrl[6:4] == 3'h7);
	c_report_end: cover property (@(posedge i_core_clk) beat && o_rpt_last);
	c_stall: cover property (@(posedge i_core_clk) o_rpt_valid && !i_rpt_ready);
endmodule : rpp_report_packer
`default_nettype wire

// ### test/rpp_cs_model.sv
// Stream partner model: snapshot requester and report sink
`default_nettype none
module rpp_cs_model (
	input  wire logic                       i_core_clk,
	input  wire logic                       i_reset,
	input  wire logic                       i_start,
	input  wire logic                       i_slow,
	input  wire logic                       i_snap_ready,
	input  wire logic                       i_rpt_valid,
	input  wire logic [31:0]                i_rpt_data,
	input  wire logic [rpp_pkg::IDX_W-1:0]  i_rpt_index,
	input  wire logic                       i_rpt_last,
	output logic                            o_snap_req,
	output logic                            o_rpt_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0]               cap [0:127];
	int                        n;
	logic [rpp_pkg::IDX_W-1:0] last_idx;
	logic                      done;
	logic [2:0]                ph;
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_snap_req  <= 1'b0;
			o_rpt_ready <= 1'b0;
			n           <= 0;
			done        <= 1'b0;
			ph          <= 3'h0;
			last_idx    <= '0;
		end else begin
			ph <= ph + 3'h1;
			// Request held until taken
			if (i_start) begin
				o_snap_req <= 1'b1;
				n          <= 0;
				done       <= 1'b0;
			end else if (o_snap_req && i_snap_ready) begin
				o_snap_req <= 1'b0;
			end
			// Stalls half the time when slow
			o_rpt_ready <= !i_slow || ph[1];
			if (i_rpt_valid && o_rpt_ready) begin
				cap[i_rpt_index] <= i_rpt_data;
				n                <= n + 1;
				if (i_rpt_last) begin
					done     <= 1'b1;
					last_idx <= i_rpt_index;
				end
			end
		end
	end
endmodule : rpp_cs_model
`default_nettype wire

// ### test/tb.sv
// Testbench for the render observer report packer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_core_clk, i_reset, i_clk_gated, i_reg_wr, i_reg_rd;
	logic [3:0]  i_reg_addr;
	logic [31:0] i_reg_wdata, o_reg_rdata, i_ctx_restore_data, o_ctx_save_data;
	logic [35:0] i_a_event;
	logic [7:0]  i_b_event, i_c_event;
	logic        i_ctx_save, i_ctx_restore, i_ctx_switch, i_ratio_change;
	logic [5:0]  i_ctx_save_idx;
	logic [31:0] i_context_tag, i_timestamp, o_rpt_data;
	logic        i_snap_req, o_snap_ready, o_rpt_valid, i_rpt_ready, o_rpt_last;
	logic [6:0]  o_rpt_index;
	logic        start, slow;
	logic [39:0] cnt [0:51];
	int          failures, checks;

	rpp_report_packer dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_gated(i_clk_gated),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_a_event(i_a_event),
		.i_b_event(i_b_event), .i_c_event(i_c_event), .i_ctx_save(i_ctx_save),
		.i_ctx_restore(i_ctx_restore), .i_ctx_save_idx(i_ctx_save_idx),
		.i_ctx_restore_data(i_ctx_restore_data), .o_ctx_save_data(o_ctx_save_data),
		.i_ctx_switch(i_ctx_switch), .i_ratio_change(i_ratio_change),
		.i_context_tag(i_context_tag), .i_timestamp(i_timestamp), .i_snap_req(i_snap_req),
		.o_snap_ready(o_snap_ready), .o_rpt_valid(o_rpt_valid), .i_rpt_ready(i_rpt_ready),
		.o_rpt_data(o_rpt_data), .o_rpt_index(o_rpt_index), .o_rpt_last(o_rpt_last));

	rpp_cs_model pm (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_start(start),
		.i_slow(slow), .i_snap_ready(o_snap_ready), .i_rpt_valid(o_rpt_valid),
		.i_rpt_data(o_rpt_data), .i_rpt_index(o_rpt_index), .i_rpt_last(o_rpt_last),
		.o_snap_req(i_snap_req), .o_rpt_ready(i_rpt_ready));

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge i_core_clk);
		i_reg_wr    <= 1'b1;
		i_reg_addr  <= a;
		i_reg_wdata <= d;
		@(posedge i_core_clk);
		i_reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(logic [3:0] a, output logic [31:0] v);
		@(posedge i_core_clk);
		i_reg_rd   <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_core_clk);
		i_reg_rd   <= 1'b0;
		#1 v = o_reg_rdata;
	endtask : rd

	function automatic logic [31:0] ctrl(logic [2:0] sel, logic run, logic mm);
		return {25'h0, sel, 1'b0, mm, run, 1'b1};
	endfunction : ctrl

	function automatic logic [31:0] ew(logic [2:0] sel, int s);
		int m;
		m = -1;
		case (sel)
			rpp_pkg::SEL_101: begin
				if (s >= 40 && s < 48) begin
					m = 4 * (s - 40);
					return {cnt[m+3][39:32], cnt[m+2][39:32], cnt[m+1][39:32], cnt[m][39:32]};
				end
				m = (s < 40) ? s - 4 : s - 12;
			end
			rpp_pkg::SEL_111: m = (s < 8) ? s + 40 : s + 28;
			rpp_pkg::SEL_010: begin
				if (s >= 16) m = s + 20;
				else if (s inside {4, 6, [8:12], 14}) m = s + 3;
			end
			default: begin
				if (s == 4 || s == 12) m = s + 4;
				else if (s inside {8, 10, 11}) m = s + 3;
			end
		endcase
		return (m < 0) ? 32'h0 : cnt[m][31:0];
	endfunction : ew

	task automatic rst();
		@(posedge i_core_clk);
		i_reset <= 1'b1;
		repeat (16) @(posedge i_core_clk);
		i_reset <= 1'b0;
	endtask : rst

	task automatic ev(logic [35:0] a, logic [7:0] b, logic [7:0] c);
		@(posedge i_core_clk);
		i_a_event <= a;
		i_b_event <= b;
		i_c_event <= c;
		@(posedge i_core_clk);
		i_a_event <= '0;
		i_b_event <= '0;
		i_c_event <= '0;
	endtask : ev

	task automatic sv(int k);
		@(posedge i_core_clk);
		i_ctx_save     <= 1'b1;
		i_ctx_save_idx <= 6'(k);
		@(posedge i_core_clk);
		i_ctx_save     <= 1'b0;
		#1 chk("save_data", o_ctx_save_data, cnt[k][31:0]);
	endtask : sv

	task automatic pulse_start();
		@(posedge i_core_clk);
		start <= 1'b1;
		@(posedge i_core_clk);
		start <= 1'b0;
	endtask : pulse_start

	task automatic t_disabled();
		logic [31:0] v;
		rd(rpp_pkg::REG_CTRL, v);
		chk("ctrl_reset", v, rpp_pkg::CTRL_RESET);
		rd(4'hf, v);
		chk("unmapped", v, 32'h0);
		pulse_start();
		repeat (30) @(posedge i_core_clk);
		chk("disabled_words", 32'(pm.n), 32'h0);
		rst();
	endtask : t_disabled

	task automatic t_count();
		logic [31:0] v, a, b;
		wr(rpp_pkg::REG_SOURCE, 32'h2b);
		wr(rpp_pkg::REG_TRIG, 32'h9);
		wr(rpp_pkg::REG_CTRL, ctrl(rpp_pkg::SEL_101, 1'b0, 1'b0));
		for (int i = 0; i < 52; i++) begin
			v = (i == 5 || i == 30) ? 32'hffff_ffff : 32'h5a00_0000 + 32'(i) * 32'h0101;
			cnt[i] = {8'h0, v};
			@(posedge i_core_clk);
			i_ctx_restore      <= 1'b1;
			i_ctx_save_idx     <= 6'(i);
			i_ctx_restore_data <= v;
			@(posedge i_core_clk);
			i_ctx_restore      <= 1'b0;
		end
		ev('1, '1, '1);
		sv(0);
		wr(rpp_pkg::REG_CTRL, ctrl(rpp_pkg::SEL_101, 1'b1, 1'b0));
		@(posedge i_core_clk);
		i_clk_gated <= 1'b1;
		ev('1, '1, '1);
		rd(rpp_pkg::REG_TICKS, a);
		rd(rpp_pkg::REG_TICKS, b);
		chk("ticks_gated", b - a, 32'h0);
		sv(36);
		@(posedge i_core_clk);
		i_clk_gated <= 1'b0;
		rd(rpp_pkg::REG_TICKS, a);
		rd(rpp_pkg::REG_TICKS, b);
		chk("ticks_free", b - a, 32'h2);
		ev(36'h0_4000_0020, 8'h08, 8'h04);
		cnt[5]  = cnt[5] + 40'h1;
		cnt[30] = cnt[30] + 40'h1;
		cnt[39] = cnt[39] + 40'h1;
		cnt[46] = cnt[46] + 40'h1;
		// Run falls here, pending for the next report
		wr(rpp_pkg::REG_CTRL, ctrl(rpp_pkg::SEL_101, 1'b0, 1'b0));
		sv(5);
		sv(39);
		sv(46);
	endtask : t_count

	task automatic snap(logic [2:0] sel, logic sl, logic [6:0] cz);
		logic [6:0] ln;
		ln = (sel == rpp_pkg::SEL_000) ? rpp_pkg::LEN_000 :
			(sel == rpp_pkg::SEL_010) ? rpp_pkg::LEN_010 :
			(sel == rpp_pkg::SEL_111) ? rpp_pkg::LEN_111 : rpp_pkg::LEN_101;
		wr(rpp_pkg::REG_CTRL, ctrl(sel, 1'b0, cz[6]));
		@(posedge i_core_clk);
		i_ctx_switch   <= cz[3];
		i_ratio_change <= cz[5];
		slow           <= sl;
		start          <= 1'b1;
		@(posedge i_core_clk);
		i_ctx_switch   <= 1'b0;
		i_ratio_change <= 1'b0;
		start          <= 1'b0;
		// Let the model clear done and the word count from the last report
		@(posedge i_core_clk);
		for (int k = 0; k < 800 && pm.done !== 1'b1; k++) @(posedge i_core_clk);
		chk("done", {31'h0, pm.done}, 32'h1);
		chk("words", 32'(pm.n), 32'(ln));
		chk("last_index", 32'(pm.last_idx), 32'(ln - 7'h1));
		chk("header", pm.cap[0], {6'h2b, cz, 1'b1, 1'b0, 17'h0});
		chk("timestamp", pm.cap[1], i_timestamp);
		chk("context_tag", pm.cap[2], i_context_tag);
		chk("ticks_seen", {31'h0, pm.cap[3] != 32'h0}, 32'h1);
		for (int k = 4; k < ln; k++) chk("slot", pm.cap[k], ew(sel, k));
	endtask : snap

	task automatic t_midreset();
		logic [31:0] v;
		wr(rpp_pkg::REG_CTRL, ctrl(rpp_pkg::SEL_101, 1'b0, 1'b0));
		slow <= 1'b1;
		pulse_start();
		@(posedge i_core_clk);
		for (int k = 0; k < 200 && pm.n < 3; k++) @(posedge i_core_clk);
		#1 chk("busy_refused", {31'h0, o_snap_ready}, 32'h0);
		rst();
		#1 chk("valid_after_reset", {31'h0, o_rpt_valid}, 32'h0);
		cnt[5] = '0;
		sv(5);
		rd(rpp_pkg::REG_CTRL, v);
		chk("ctrl_after_reset", v, rpp_pkg::CTRL_RESET);
	endtask : t_midreset

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	initial begin
		{i_clk_gated, i_reg_wr, i_reg_rd, i_ctx_save, i_ctx_restore} = '0;
		{i_ctx_switch, i_ratio_change, start, slow} = '0;
		{i_reg_addr, i_reg_wdata, i_a_event, i_b_event, i_c_event} = '0;
		i_ctx_save_idx     = '0;
		i_ctx_restore_data = '0;
		i_timestamp        = 32'h1357_9bdf;
		i_context_tag      = 32'hc0de_0042;
		failures           = 0;
		checks             = 0;
		i_reset            = 1'b1;
		repeat (16) @(posedge i_core_clk);
		i_reset <= 1'b0;
		t_disabled();
		t_count();
		snap(rpp_pkg::SEL_101, 1'b0, 7'h58);
		snap(rpp_pkg::SEL_111, 1'b1, 7'h08);
		snap(rpp_pkg::SEL_010, 1'b1, 7'h20);
		snap(rpp_pkg::SEL_000, 1'b0, 7'h40);
		t_midreset();
		print_verdict();
	end

	initial begin
		#200000;
		failures++;
		print_verdict();
	end
endmodule : tb
`default_nettype wire
